// ---- design/etc_pkg.sv ----
// constants, register map and carrier types for the prescaled 8-bit timer
package etc_pkg;

    localparam logic [1:0] REG_COUNT   = 2'h0;
    localparam logic [1:0] REG_OPTIONS = 2'h1;
    localparam logic [1:0] REG_INTCTL  = 2'h2;

    localparam logic [7:0] OPTIONS_RESET = 8'hFF;
    localparam logic [7:0] INTCTL_RESET  = 8'h00;
    localparam logic [7:0] COUNT_RESET   = 8'h00;

    // option register field positions
    localparam int OPT_CS_BIT   = 5;
    localparam int OPT_SE_BIT   = 4;
    localparam int OPT_PSA_BIT  = 3;
    localparam int OPT_RATE_LSB = 0;

    // interrupt control field positions
    localparam int INT_EN_BIT   = 5;
    localparam int INT_FLAG_BIT = 2;

    localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;
    // one instruction cycle is four phase clocks
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [1:0] PHASE_Q2   = 2'h1;
    localparam logic [1:0] PHASE_Q4   = 2'h3;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } etc_bus_req_t;

    typedef struct packed {
        logic       cs;
        logic       se;
        logic       prescaler_assign;
        logic [2:0] rate;
    } etc_opt_t;

endpackage

// ---- design/etc_timer.sv ----
// prescaled 8-bit timer/counter with shared watchdog prescaler
//
// Contract
// - source bit 0: timer mode, one advance per instruction cycle
// - a count write blocks counting for the next two instruction cycles
// - source bit 1: count edges of the external count pin
// - edge bit 1 counts falling edges, 0 counts rising edges
// - prescaler serves timer when assign bit 0, watchdog when 1
// - timer runs undivided only while prescaler belongs to watchdog
// - prescaler hidden from software; count writes clear it if timer's
// - watchdog clear instruction clears prescaler when watchdog owns it
// - rollover FFh to 00h sets overflow flag; only software zero clears
// - interrupt request only while enable and overflow flag both set
// - timer frozen during sleep, so no wake from overflow
// - counter mode samples prescaler output at phases Q2 and Q4
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns

module etc_timer (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire etc_pkg::etc_bus_req_t bus_req,
    output logic [7:0]                 rdata,
    input  wire logic                  ext_count_input,
    input  wire logic                  sleep_mode,
    input  wire logic                  watchdog_clear_instr,
    output logic                       watchdog_tick,
    output logic                       timer_irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [7:0] count_q;
    logic [7:0] count_d;
    logic [7:0] options_q;
    logic [7:0] intctl_q;
    logic [7:0] intctl_d;
    logic [7:0] rdata_q;
    logic [7:0] presc_q;
    logic [7:0] presc_d;
    logic [1:0] phase_q;
    logic [1:0] hold_q;
    logic [1:0] hold_d;
    logic [2:0] pin_sync_q;
    logic       pin_level_q;
    logic       edge_q;
    logic       sample_q;
    logic       sample_prev_q;
    logic       irq_q;
    logic       wdt_tick_q;

    etc_pkg::etc_opt_t opt;
    // one driver for the whole struct keeps the field views consistent
    assign opt = '{cs:   options_q[etc_pkg::OPT_CS_BIT],
                   se:   options_q[etc_pkg::OPT_SE_BIT],
                   prescaler_assign:  options_q[etc_pkg::OPT_PSA_BIT],
                   rate: options_q[etc_pkg::OPT_RATE_LSB +: 3]};

    wire wr_count   = bus_req.wr && bus_req.addr == etc_pkg::REG_COUNT;
    wire wr_options = bus_req.wr && bus_req.addr == etc_pkg::REG_OPTIONS;
    wire wr_intctl  = bus_req.wr && bus_req.addr == etc_pkg::REG_INTCTL;

    // terminal count of an n-stage divider: low bits all ones
    function automatic logic presc_terminal(input logic [7:0] cnt,
                                            input logic [2:0] code);
        logic [7:0] mask;
        mask = 8'hFF >> (3'h7 - code);
        return (cnt & mask) == mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // phase clocks and pin synchroniser

    wire instr_end = phase_q == etc_pkg::PHASE_LAST;
    // only the agreeing second and third stages are looked at
    wire pin_agree = pin_sync_q[1] == pin_sync_q[2];
    wire pin_next  = pin_agree ? pin_sync_q[2] : pin_level_q;
    // falling if edge bit set, else rising
    wire pin_edge  = (pin_next != pin_level_q) &&
                     (opt.se ? !pin_next : pin_next);

    ////////////////////////////////////////////////////////////////////////
    // source selection and prescaler

    wire running  = !sleep_mode;
    wire src_tick = running &&
                    (opt.cs ? edge_q : instr_end);
    // watchdog ticks are taken per instruction cycle
    wire wdt_src  = running && instr_end;
    wire presc_in = opt.prescaler_assign ? wdt_src : src_tick;
    // watchdog ratio is half the timer one: one stage fewer
    wire [2:0] wdt_code = (opt.rate == 3'h0) ? 3'h0 : opt.rate - 3'h1;
    wire presc_hit = presc_in &&
        (opt.prescaler_assign ? (opt.rate == 3'h0 || presc_terminal(presc_q, wdt_code))
                 : presc_terminal(presc_q, opt.rate));
    wire presc_clr = (wr_count && !opt.prescaler_assign) ||
                     (watchdog_clear_instr && opt.prescaler_assign);

    always_comb begin
        presc_d = presc_q;
        if (presc_clr) begin
            presc_d = 8'h00;
        end else if (presc_in) begin
            presc_d = presc_q + 8'h01;
        end
    end

    // bypass gives 1:1 when the watchdog owns the divider
    wire timer_raw = opt.prescaler_assign ? src_tick
                             : (presc_hit && !presc_clr);

    ////////////////////////////////////////////////////////////////////////
    // count register, write hold and overflow

    // counter-mode ticks resynchronised at Q2/Q4 before reaching the count
    wire q_sample = phase_q == etc_pkg::PHASE_Q2 ||
                    phase_q == etc_pkg::PHASE_Q4;
    wire cnt_tick = opt.cs ? (sample_q && !sample_prev_q && q_sample)
                           : timer_raw;
    wire inc      = cnt_tick && running && hold_q == 2'h0;
    wire overflow = inc && count_q == 8'hFF;

    always_comb begin
        count_d = count_q;
        hold_d  = hold_q;
        if (wr_count) begin
            count_d = bus_req.wdata;
            hold_d  = etc_pkg::WRITE_HOLD_CYCLES;
        end else begin
            if (inc) begin
                count_d = count_q + 8'h01;
            end
            if (hold_q != 2'h0 && instr_end) begin
                hold_d = hold_q - 2'h1;
            end
        end
    end

    always_comb begin
        intctl_d = intctl_q;
        if (wr_intctl) begin
            intctl_d = bus_req.wdata;
        end
        // hardware set wins over a same-cycle clear
        if (overflow) begin
            intctl_d[etc_pkg::INT_FLAG_BIT] = 1'b1;
        end
    end

    wire irq_d = intctl_d[etc_pkg::INT_EN_BIT] &&
                 intctl_d[etc_pkg::INT_FLAG_BIT];

    wire [7:0] rd_mux = (bus_req.addr == etc_pkg::REG_COUNT)   ? count_q :
                        (bus_req.addr == etc_pkg::REG_OPTIONS) ? options_q :
                        (bus_req.addr == etc_pkg::REG_INTCTL)  ? intctl_q :
                        8'h00;

    ////////////////////////////////////////////////////////////////////////
    // flip-flops

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q    <= 2'h0;
            pin_sync_q <= 3'h0;
            pin_level_q <= 1'b0;
            edge_q     <= 1'b0;
        end else begin
            phase_q    <= phase_q + 2'h1;
            pin_sync_q <= {pin_sync_q[1:0], ext_count_input};
            pin_level_q <= pin_next;
            edge_q     <= pin_edge;
        end
    end

    // sample held prescaler output, sampled only on Q2/Q4
    always_ff @(posedge clk) begin
        if (reset) begin
            sample_q      <= 1'b0;
            sample_prev_q <= 1'b0;
        end else begin
            if (timer_raw) begin
                sample_q <= 1'b1;
            end else if (q_sample && sample_q && sample_prev_q) begin
                sample_q <= 1'b0;
            end
            if (q_sample) begin
                sample_prev_q <= sample_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q    <= etc_pkg::COUNT_RESET;
            hold_q     <= 2'h0;
            presc_q    <= 8'h00;
            options_q  <= etc_pkg::OPTIONS_RESET;
            intctl_q   <= etc_pkg::INTCTL_RESET;
            irq_q      <= 1'b0;
            rdata_q    <= 8'h00;
            wdt_tick_q <= 1'b0;
        end else begin
            count_q    <= count_d;
            hold_q     <= hold_d;
            presc_q    <= presc_d;
            intctl_q   <= intctl_d;
            irq_q      <= irq_d;
            rdata_q    <= bus_req.rd ? rd_mux : 8'h00;
            wdt_tick_q <= opt.prescaler_assign ? (presc_hit && !presc_clr) : wdt_src;
            if (wr_options) begin
                options_q <= bus_req.wdata;
            end
        end
    end

    assign rdata         = rdata_q;
    assign timer_irq     = irq_q;
    assign watchdog_tick = wdt_tick_q;

endmodule

// ---- tb/etc_timer_assertions.sv ----
// port checker for the prescaled 8-bit timer
`timescale 1ns/1ns
module etc_timer_assertions (
    input wire logic                  clk,
    input wire logic                  reset,
    input wire etc_pkg::etc_bus_req_t bus_req,
    input wire logic [7:0]            rdata,
    input wire logic                  ext_count_input,
    input wire logic                  sleep_mode,
    input wire logic                  watchdog_clear_instr,
    input wire logic                  watchdog_tick,
    input wire logic                  timer_irq
);
default clocking @(posedge clk); endclocking
default disable iff (reset);
wire wr_cnt = bus_req.wr && bus_req.addr == 2'h0;
wire rd_cnt = bus_req.rd && bus_req.addr == 2'h0;
wire wr_opt = bus_req.wr && bus_req.addr == 2'h1;
wire rd_opt = bus_req.rd && bus_req.addr == 2'h1;
wire wr_int = bus_req.wr && bus_req.addr == 2'h2;
////////////////////////////////////////////////////////////////////////////
chk_read_idle: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("rdata not idle");
chk_read_hole: assert property (bus_req.rd && bus_req.addr == 2'h3
    |=> rdata == 8'h00) else $error("unmapped read not zero");
chk_count_hold: assert property (wr_cnt ##1 rd_cnt
    |=> rdata == $past(bus_req.wdata, 2)) else $error("count moved");
chk_opt_back: assert property (wr_opt ##1 rd_opt
    |=> rdata == $past(bus_req.wdata, 2)) else $error("options lost");
chk_irq_masked: assert property (wr_int && !bus_req.wdata[5]
    |-> ##2 !timer_irq) else $error("masked irq high");
chk_irq_sticky: assert property (timer_irq && !wr_int
    && !$past(wr_int) |=> timer_irq) else $error("irq dropped");
chk_tick_space: assert property (watchdog_tick
    |=> !watchdog_tick [*3]) else $error("tick spacing");
chk_sleep_quiet: assert property ($rose(timer_irq)
    && !$past(wr_int) |-> !$past(sleep_mode))
    else $error("irq rose in sleep");
endmodule

// ---- tb/etc_pulse_src.sv ----
// count pin source: toggles the pin a given number of times
`timescale 1ns/1ns
module etc_pulse_src (
    input wire logic       clk,
    input wire logic       go,
    input wire logic [3:0] n_toggle,
    output logic           ext_count_input,
    output logic           src_busy
);
logic [3:0] left_q = 4'h0;
logic [3:0] hold_q = 4'h0;
initial ext_count_input = 1'b0;
assign src_busy = left_q != 4'h0;
// each level held 12 clocks so the phase sampler cannot miss it
always @(posedge clk) begin
    if (go) begin
        left_q <= n_toggle;
        hold_q <= 4'hB;
    end else if (src_busy && hold_q == 4'h0) begin
        ext_count_input <= ~ext_count_input;
        left_q          <= left_q - 4'h1;
        hold_q          <= 4'hB;
    end else if (src_busy) begin
        hold_q <= hold_q - 4'h1;
    end
end
endmodule

// ---- tb/etc_timer_test.sv ----
// self-checking bench for the prescaled 8-bit timer
`timescale 1ns/1ns
module etc_timer_test;
logic                  clk = 1'b0;
logic                  reset = 1'b1;
etc_pkg::etc_bus_req_t bus_req = '0;
logic                  sleep_mode = 1'b0;
logic                  watchdog_clear_instr = 1'b0;
logic                  go = 1'b0;
logic [3:0]            n_toggle = 4'h0;
logic [7:0]            rdata;
logic                  ext_count_input;
logic                  watchdog_tick;
logic                  timer_irq;
logic                  src_busy;
logic [7:0]            v;
logic [7:0]            w0;
logic [7:0]            opt;
int                    n_mismatch = 0;
int                    num_checks = 0;
int                    nt = 0;
always #4 clk = ~clk;
etc_timer dut (.*);
etc_pulse_src src (.*);
////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask
// a write is left standing so a read may follow with no gap
task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
endtask
task automatic rd(input logic [1:0] a);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 v = rdata;
    @(posedge clk);
endtask
task automatic idle(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk);
endtask
// counts watchdog ticks over 64 clocks, returns on a rising edge
task automatic count_ticks;
    nt = 0;
    repeat (64) begin
        @(posedge clk);
        #1 nt += int'(watchdog_tick);
    end
    @(posedge clk);
endtask
task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rd(2'h1);
    check(v, 8'hFF);
    rd(2'h2);
    check(v, 8'h00);
    rd(2'h0);
    check(v, 8'h00);
    rd(2'h3);
    check(v, 8'h00);
    // window of three count periods at every ratio, undivided last
    for (int i = 0; i <= 8; i++) begin
        opt = (i == 8) ? 8'h08 : {5'h00, i[2:0]};
        if (i == 8) begin
            // clear count and watchdog before handing over the divider
            wr(2'h0, 8'h00);
            watchdog_clear_instr <= 1'b1;
            idle(1);
            watchdog_clear_instr <= 1'b0;
        end
        wr(2'h1, opt);
        rd(2'h1);
        check(v, opt);
        idle(8);
        rd(2'h0);
        w0 = v;
        idle(12 * ((i == 8) ? 1 : (2 << i)) - 2);
        rd(2'h0);
        check(v - w0, 8'h03);
    end
    wr(2'h0, 8'h10);
    rd(2'h0);
    idle(5);
    rd(2'h0);
    check(v, 8'h10);
    wr(2'h1, 8'h07);
    wr(2'h0, 8'h00);
    idle(512);
    wr(2'h0, 8'h20);
    idle(900);
    rd(2'h0);
    check(v, 8'h20);
    wr(2'h1, 8'h08);
    wr(2'h0, 8'hFE);
    wr(2'h2, 8'h20);
    sleep_mode <= 1'b1;
    idle(60);
    rd(2'h0);
    check(v, 8'hFE);
    sleep_mode <= 1'b0;
    for (int k = 0; k < 40 && timer_irq !== 1'b1; k++) @(posedge clk);
    check({7'h00, timer_irq}, 8'h01);
    rd(2'h2);
    check(v, 8'h24);
    wr(2'h2, 8'h20);
    rd(2'h2);
    check(v, 8'h20);
    check({7'h00, timer_irq}, 8'h00);
    wr(2'h2, 8'h00);
    wr(2'h0, 8'hFE);
    idle(40);
    rd(2'h2);
    check(v, 8'h04);
    // three toggles from low: two rising edges, one falling
    for (int s = 0; s < 2; s++) begin
        wr(2'h1, s ? 8'h38 : 8'h28);
        wr(2'h0, 8'h00);
        idle(12);
        n_toggle <= (s ? 4'h3 : 4'h3);
        go <= 1'b1;
        repeat (2) @(posedge clk);
        go <= 1'b0;
        while (src_busy) @(posedge clk);
        idle(20);
        rd(2'h0);
        check(v, s ? 8'h01 : 8'h02);
        n_toggle <= 4'h1;
        go <= 1'b1;
        repeat (2) @(posedge clk);
        go <= 1'b0;
        while (src_busy) @(posedge clk);
    end
    // watchdog owns the divider at code 1: one tick per two cycles
    wr(2'h1, 8'h09);
    idle(8);
    count_ticks();
    check(nt[7:0], 8'h08);
    watchdog_clear_instr <= 1'b1;
    idle(2);
    count_ticks();
    watchdog_clear_instr <= 1'b0;
    check(nt[7:0], 8'h00);
    final_report();
end
initial begin
    #200000;
    n_mismatch++;
    final_report();
end
endmodule
bind etc_timer etc_timer_assertions chk (.*);
